// ### stwc_counter.sv
// Top: 16-bit timer / external trigger / event / window counter with Wishbone registers
// Operation
// [R01] Six modes selectable; pulse and pulse-output idle
// [R02] Timer counts source clock, match interrupts and clears
// [R03] Auto-capture copies count every source clock
// [R04] Software waits one source clock before capture read
// [R05] Capture read only while running and enabled
// [R06] Select codes give fc/2^11, fc/2^7, fc/2^3
// [R07] Trigger timer waits chosen edge, then counts
// [R08] Stop select 1: opposite edge clears, halts silently
// [R09] Stop select 0: opposite edge, early trigger ignored
// [R10] Input filter rejects short pulses, bypassed when slow
// [R11] Trigger pulses must be at least 12/fc
// [R12] Event mode counts selected pin edges, clears on match
// [R13] Event match evaluated at the opposite edge
// [R14] Event levels held two machine cycles minimum
// [R15] Auto-capture also works in event mode
// [R16] Window mode counts source clock gated by pin
// [R17] Window pulse much slower than source clock
// [R18] Upper byte write commits at next source clock (code: commits only on src_tick, so never in event mode)
// [R19] Stop power mode forces start control to stop
// [R20] Configuration changed only while stopped
// [R21] Period register must exceed one
// [R22] Pin synchronised; interrupt is one-cycle pulse
//
// The Wishbone slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module stwc_counter
  import stwc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic counter_input_pin_i,
  input wire logic slow_clock_tick_i,
  input wire logic low_speed_mode_i,
  input wire logic stop_mode_entry_i,
  output logic counter_interrupt_request_o
);
  logic [1:0] operating_mode_select;
  logic [1:0] source_clock_select;
  logic [1:0] start_control;
  logic trigger_stop_select;
  logic auto_capture_enable;
  logic divider_option;
  logic [15:0] period_register;
  logic [15:0] period_shadow;
  logic [7:0] period_low_hold;
  logic period_pending;
  logic [15:0] capture_register;
  logic [15:0] count;
  logic [15:0] next_count;
  logic match_hold;
  logic next_irq;
  stwc_state_type state;
  stwc_state_type next_state;
  logic src_tick;
  logic pin_level;
  logic pin_rise;
  logic pin_fall;
  logic wb_req;
  logic wr_ctrl;
  logic wr_period;
  logic trig_edge;
  logic opp_edge;
  logic active_level;
  logic ext_trig_mode;
  logic event_mode;
  logic count_en;
  logic running;
  logic matched;

  stwc_prescaler u_presc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clk_sel_i(source_clock_select),
    .div_opt_i(divider_option),
    .slow_tick_i(slow_clock_tick_i),
    .low_speed_i(low_speed_mode_i),
    .tick_o(src_tick)
  );

  stwc_pin_filter u_filter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(counter_input_pin_i),
    .bypass_i(low_speed_mode_i),
    .level_o(pin_level),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  // Wishbone classic: one-cycle ack, dropped in the next cycle
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_ctrl = wb_req && wb_we_i && wb_adr_i == ADDR_CTRL;
  assign wr_period = wb_req && wb_we_i && wb_adr_i == ADDR_PERIOD;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (wb_req && !wb_we_i) begin
      unique case (wb_adr_i)
        ADDR_CTRL: wb_dat_o <= {23'h00_0000, divider_option, auto_capture_enable,
                                trigger_stop_select, start_control, source_clock_select,
                                operating_mode_select};
        ADDR_PERIOD: wb_dat_o <= {16'h0000, period_register};
        ADDR_CAPTURE: wb_dat_o <= {16'h0000, capture_register};
        ADDR_STATUS: wb_dat_o <= {27'h000_0000, period_pending, pin_level, state};
        default: wb_dat_o <= '0;
      endcase
    end
  end

  // Control register; stop-mode entry overrides software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {operating_mode_select, source_clock_select, start_control} <= 6'h00;
      trigger_stop_select <= 1'b0;
      auto_capture_enable <= 1'b0;
      divider_option <= 1'b0;
    end else begin
      if (wr_ctrl && wb_sel_i[0]) begin
        operating_mode_select <= wb_dat_i[MODE_LSB +: 2];
        source_clock_select <= wb_dat_i[CLKSEL_LSB +: 2];
        start_control <= wb_dat_i[START_LSB +: 2];
        trigger_stop_select <= wb_dat_i[TRIG_STOP_BIT];
        auto_capture_enable <= wb_dat_i[ACAP_BIT];
      end
      if (wr_ctrl && wb_sel_i[1]) begin
        divider_option <= wb_dat_i[DIVOPT_BIT];
      end
      if (stop_mode_entry_i) begin
        start_control <= START_STOP; // [R19]
      end
    end
  end

  // Period: low byte held, upper byte arms commit at next src_tick; event mode has none, so it stays pending
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      period_low_hold <= REG16_RESET[7:0];
      period_shadow <= REG16_RESET;
      period_pending <= 1'b0;
      period_register <= REG16_RESET;
    end else begin
      if (wr_period && wb_sel_i[0]) begin
        period_low_hold <= wb_dat_i[7:0];
      end
      if (wr_period && wb_sel_i[1]) begin
        period_shadow <= {wb_dat_i[15:8], wb_sel_i[0] ? wb_dat_i[7:0] : period_low_hold}; // [R18]
        period_pending <= 1'b1;
      end else if (period_pending && src_tick) begin
        period_register <= period_shadow; // [R18]
        period_pending <= 1'b0;
      end
    end
  end

  // Mode decode; pulse width and pulse output modes hold the counter idle
  assign event_mode = operating_mode_select == MODE_TIMER && source_clock_select == CLK_SEL_EXT;
  assign ext_trig_mode = operating_mode_select == MODE_TIMER && !event_mode
                         && start_control[1]; // [R01]
  assign trig_edge = start_control == START_RISE ? pin_rise : pin_fall;
  assign opp_edge = start_control == START_RISE ? pin_fall : pin_rise;
  assign active_level = start_control == START_RISE ? pin_level : !pin_level;
  assign running = start_control != START_STOP
                   && operating_mode_select != MODE_PULSE
                   && operating_mode_select != MODE_PPG; // [R01]
  assign matched = count == period_register;

  always_comb begin
    count_en = 1'b0;
    if (operating_mode_select == MODE_WINDOW) begin
      count_en = src_tick && active_level && start_control[1]; // [R16]
    end else if (event_mode) begin
      count_en = trig_edge && start_control[1]; // [R12]
    end else begin
      count_en = src_tick && state == STWC_RUN; // [R02] [R07]
    end
  end

  // Run state for the external trigger timer
  always_comb begin
    next_state = state;
    if (!running) begin
      next_state = STWC_IDLE;
    end else begin
      unique case (state)
        STWC_IDLE: next_state = ext_trig_mode ? STWC_ARMED : STWC_RUN;
        STWC_ARMED: next_state = trig_edge ? STWC_RUN : STWC_ARMED; // [R07]
        STWC_RUN: begin
          if (ext_trig_mode && count_en && matched) begin
            next_state = STWC_ARMED; // [R08] [R09]
          end else if (ext_trig_mode && trigger_stop_select && opp_edge) begin
            next_state = STWC_ARMED; // [R08]
          end
        end
        default: next_state = STWC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= STWC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Counter and match handling
  always_comb begin
    next_count = count;
    next_irq = 1'b0;
    if (!running) begin
      next_count = COUNT_ZERO;
    end else if (ext_trig_mode && state == STWC_RUN && trigger_stop_select && opp_edge
                 && !(count_en && matched)) begin
      next_count = COUNT_ZERO; // [R08]
    end else if (event_mode) begin
      if (match_hold && opp_edge) begin
        next_count = COUNT_ZERO; // [R13]
        next_irq = 1'b1;
      end else if (count_en) begin
        next_count = count + COUNT_ONE; // [R12]
      end
    end else if (count_en) begin
      if (matched) begin
        next_count = COUNT_ZERO; // [R02] [R16]
        next_irq = 1'b1;
      end else begin
        next_count = count + COUNT_ONE;
      end
    end
  end

  // Event match is latched at the counting edge, acted on at the opposite one
  always_ff @(posedge clk_i) begin
    if (rst_i || !running || !event_mode) begin
      match_hold <= 1'b0;
    end else if (count_en) begin
      match_hold <= (count + COUNT_ONE) == period_register; // [R13]
    end else if (opp_edge) begin
      match_hold <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= COUNT_ZERO;
    end else begin
      count <= next_count;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      counter_interrupt_request_o <= 1'b0;
    end else begin
      counter_interrupt_request_o <= next_irq; // [R22]
    end
  end

  // Capture follows the count on each counter source clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      capture_register <= REG16_RESET;
    end else if (auto_capture_enable && running && (event_mode ? count_en : src_tick)) begin
      capture_register <= count; // [R03] [R15]
    end
  end
endmodule
`default_nettype wire

// ### stwc_counter_assertions.sv
// Bus and interrupt checker for the timer counter
`timescale 1ns/1ps
`default_nettype none
module stwc_counter_assertions
  import stwc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic stop_mode_entry_i,
  input wire logic counter_interrupt_request_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic rd_ack;
  assign rd_ack = wb_ack_o && !wb_we_i;
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack_pulse;
    ##1 wb_ack_o ##1 !wb_ack_o;
  endsequence
  property p_ack_once;
    s_req |-> s_ack_pulse;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack not a single pulse after request");
  property p_ack_cause;
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_irq_pulse;
    counter_interrupt_request_o |=> !counter_interrupt_request_o;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt wider than one cycle");
  property p_rst_quiet;
    $fell(rst_i) |-> !wb_ack_o && !counter_interrupt_request_o;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active after reset");
  // Four cycles let an interrupt already in flight drain
  property p_stop_quiet;
    stop_mode_entry_i [*4] |-> !counter_interrupt_request_o;
  endproperty
  a_stop_quiet: assert property (p_stop_quiet) else $error("interrupt while stopped");
  property p_unmapped;
    rd_ack && wb_adr_i[1:0] != 2'h0 |-> wb_dat_o == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_ctrl_width;
    rd_ack && wb_adr_i == ADDR_CTRL |-> wb_dat_o[31:9] == '0;
  endproperty
  a_ctrl_width: assert property (p_ctrl_width) else $error("control upper bits set");
  property p_reg16_width;
    rd_ack && (wb_adr_i == ADDR_PERIOD || wb_adr_i == ADDR_CAPTURE) |->
      wb_dat_o[31:16] == 16'h0000;
  endproperty
  a_reg16_width: assert property (p_reg16_width) else $error("16-bit register too wide");
  property p_status_onehot;
    rd_ack && wb_adr_i == ADDR_STATUS |-> $onehot(wb_dat_o[2:0]);
  endproperty
  a_status_onehot: assert property (p_status_onehot) else $error("state not one-hot");
endmodule
bind stwc_counter stwc_counter_assertions i_chk (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .stop_mode_entry_i(stop_mode_entry_i),
  .counter_interrupt_request_o(counter_interrupt_request_o)
);
`default_nettype wire

// ### stwc_pin_filter.sv
// Synchroniser and noise filter for the counter input pin
`timescale 1ns/1ps
`default_nettype none
module stwc_pin_filter
  import stwc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  input wire logic bypass_i,
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);
  logic sync1;
  logic sync2;
  logic [2:0] stable_cnt;
  logic next_level;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
    end else begin
      sync1 <= pin_i; // [R22]
      sync2 <= sync1;
    end
  end

  // A new level must persist beyond the reject window to be accepted
  always_ff @(posedge clk_i) begin
    if (rst_i || sync2 == level_o) begin
      stable_cnt <= '0;
    end else if (stable_cnt != FILT_MAX) begin
      stable_cnt <= stable_cnt + 3'h1;
    end
  end

  assign next_level = (bypass_i || stable_cnt == FILT_MAX) ? sync2 : level_o; // [R10]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_o <= 1'b0;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end else begin
      level_o <= next_level;
      rise_o <= next_level & ~level_o;
      fall_o <= ~next_level & level_o;
    end
  end
endmodule
`default_nettype wire

// ### stwc_pkg.sv
// Package for the 16-bit timer / event / window counter
package stwc_pkg;
  // Register word offsets (byte addresses)
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_PERIOD = 4'h4;
  localparam logic [3:0] ADDR_CAPTURE = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hc;
  // Control register field positions
  localparam int MODE_LSB = 0;
  localparam int CLKSEL_LSB = 2;
  localparam int START_LSB = 4;
  localparam int TRIG_STOP_BIT = 6;
  localparam int ACAP_BIT = 7;
  localparam int DIVOPT_BIT = 8;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] REG16_RESET = 16'hffff;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  // Mode select codes
  localparam logic [1:0] MODE_TIMER = 2'h0;
  localparam logic [1:0] MODE_WINDOW = 2'h1;
  localparam logic [1:0] MODE_PULSE = 2'h2;
  localparam logic [1:0] MODE_PPG = 2'h3;
  // Start control codes
  localparam logic [1:0] START_STOP = 2'h0;
  localparam logic [1:0] START_CMD = 2'h1;
  localparam logic [1:0] START_RISE = 2'h2;
  localparam logic [1:0] START_FALL = 2'h3;
  // Source clock select codes
  localparam logic [1:0] CLK_SEL_SLOW = 2'h0;
  localparam logic [1:0] CLK_SEL_MID = 2'h1;
  localparam logic [1:0] CLK_SEL_FAST = 2'h2;
  localparam logic [1:0] CLK_SEL_EXT = 2'h3;
  // Divider taps: fc/2^11, fc/2^7, fc/2^3 and fs/2^3 on a free-running prescaler
  localparam int PRESC_W = 11;
  localparam int TAP_SLOW = 10;
  localparam int TAP_MID = 6;
  localparam int TAP_FAST = 2;
  // Noise filter: reject 4/fc or less; fc taken equal to the 125 MHz system clock
  localparam int CLK_MHZ = 125;
  localparam int FILT_NS = 32;
  localparam int FILT_CYCLES = (FILT_NS * CLK_MHZ + 999) / 1000;
  localparam logic [2:0] FILT_MAX = 3'(FILT_CYCLES);
  // Counter control state
  typedef enum logic [2:0] {
    STWC_IDLE = 3'b001,
    STWC_ARMED = 3'b010,
    STWC_RUN = 3'b100
  } stwc_state_type;
endpackage

// ### stwc_prescaler.sv
// Free-running prescaler producing source-clock enable pulses
`timescale 1ns/1ps
`default_nettype none
module stwc_prescaler
  import stwc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] clk_sel_i,
  input wire logic div_opt_i,
  input wire logic slow_tick_i,
  input wire logic low_speed_i,
  output logic tick_o
);
  logic [PRESC_W-1:0] presc;
  logic [PRESC_W-1:0] next_presc;
  logic [3:0] slow_cnt;
  logic slow_tap;
  logic tap;

  assign next_presc = presc + 1'b1;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      presc <= '0;
    end else begin
      presc <= next_presc;
    end
  end

  // fs/2^3 from the low-frequency clock enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slow_cnt <= '0;
    end else if (slow_tick_i) begin
      slow_cnt <= slow_cnt + 4'h1;
    end
  end

  assign slow_tap = slow_tick_i && (slow_cnt[2:0] == 3'h7);

  // Rising edge of a prescaler bit becomes a one-cycle tick
  always_comb begin
    tap = 1'b0;
    if (low_speed_i || (div_opt_i && clk_sel_i == CLK_SEL_SLOW)) begin
      tap = (clk_sel_i == CLK_SEL_SLOW) && slow_tap; // [R06]
    end else begin
      unique case (clk_sel_i)
        CLK_SEL_SLOW: tap = ~presc[TAP_SLOW] & next_presc[TAP_SLOW]; // [R06]
        CLK_SEL_MID: tap = ~presc[TAP_MID] & next_presc[TAP_MID];
        CLK_SEL_FAST: tap = ~presc[TAP_FAST] & next_presc[TAP_FAST];
        CLK_SEL_EXT: tap = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= tap;
    end
  end
endmodule
`default_nettype wire

// ### stwc_pulse_src.sv
// External pulse source model for the counter input pin
`timescale 1ns/1ps
`default_nettype none
module stwc_pulse_src (
  input wire logic clk_i,
  output logic pin_o
);
  initial pin_o = 1'b0;
  // Callers keep n at 20 or more, except short glitches meant for the filter
  task automatic hold(input logic lvl, input int n);
    pin_o <= lvl;
    repeat (n) @(posedge clk_i);
  endtask
  task automatic pulses(input int k, input int w);
    repeat (k) begin
      hold(1'b1, w);
      hold(1'b0, w);
    end
  endtask
endmodule
`default_nettype wire

// ### tb_stwc_counter.sv
// Self-checking bench for the timer counter
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin err_total++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_stwc_counter
  import stwc_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack;
  logic irq;
  logic pin;
  logic stop = 1'b0;
  logic slow_tick = 1'b0;
  logic [3:0] tick_n = 4'h0;
  logic ack_s;
  logic [31:0] dat_s;
  int err_total = 0;
  int checks_done = 0;
  int irq_cnt = 0;
  int irq_hi = 0;
  int cyc_n = 0;
  int last_irq = 0;
  int gap = 0;
  always #4 clk_i = ~clk_i;
  // Sample answers mid-cycle so the edge never races the design
  always @(negedge clk_i) begin
    ack_s = ack;
    dat_s = rdat;
  end
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    tick_n <= tick_n + 4'h1;
    slow_tick <= tick_n == 4'hf;
    if (irq === 1'b1) begin
      irq_cnt <= irq_cnt + 1;
      gap <= cyc_n - last_irq;
      last_irq <= cyc_n;
      if (pin) irq_hi <= irq_hi + 1;
    end
  end
  stwc_counter i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .counter_input_pin_i(pin), .slow_clock_tick_i(slow_tick), .low_speed_mode_i(1'b0),
    .stop_mode_entry_i(stop), .counter_interrupt_request_o(irq));
  stwc_pulse_src i_src (.clk_i(clk_i), .pin_o(pin));
  task automatic bus(input logic w, input logic [3:0] a, input logic [3:0] s,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_s !== 1'b1 && n < 40);
    `CHK(ack_s, 1'b1)
    q = dat_s;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, s, d, q);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 4'hf, 32'h0000_0000, q);
    `CHK(q & m, e)
  endtask
  task automatic set_ctrl(input logic [31:0] cfg, input logic [1:0] st);
    wr(ADDR_CTRL, 4'h3, cfg);
    wr(ADDR_CTRL, 4'h3, cfg | (32'(st) << START_LSB));
  endtask
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    logic [31:0] q;
    int base;
    int d1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ADDR_CTRL, 32'hffff_ffff, 32'h0000_0000);
    rd(ADDR_PERIOD, 32'hffff_ffff, 32'h0000_ffff);
    rd(ADDR_CAPTURE, 32'hffff_ffff, 32'h0000_ffff);
    rd(ADDR_STATUS, 32'h0000_0007, 32'h0000_0001);
    wr(4'h2, 4'hf, 32'hffff_ffff);
    rd(4'h2, 32'hffff_ffff, 32'h0000_0000);
    wr(ADDR_PERIOD, 4'h3, 32'h0000_0004);
    set_ctrl(32'h0000_0088, START_CMD);
    repeat (240) @(posedge clk_i);
    d1 = gap;
    repeat (80) @(posedge clk_i);
    `CHK(gap, d1)
    `CHK(d1 % 8, 0)
    bus(1'b0, ADDR_CAPTURE, 4'hf, 32'h0000_0000, q);
    `CHK(q <= 32'h0000_0004, 1'b1)
    rd(ADDR_STATUS, 32'h0000_0007, 32'h0000_0004);
    stop <= 1'b1;
    repeat (4) @(posedge clk_i);
    stop <= 1'b0;
    rd(ADDR_CTRL, 32'h0000_0030, 32'h0000_0000);
    base = irq_cnt;
    repeat (200) @(posedge clk_i);
    `CHK(irq_cnt - base, 0)
    wr(ADDR_PERIOD, 4'h1, 32'h0000_0009);
    repeat (20) @(posedge clk_i);
    rd(ADDR_PERIOD, 32'hffff_ffff, 32'h0000_0004);
    wr(ADDR_PERIOD, 4'h2, 32'h0000_0000);
    repeat (20) @(posedge clk_i);
    rd(ADDR_PERIOD, 32'hffff_ffff, 32'h0000_0009);
    set_ctrl(32'h0000_0048, START_RISE);
    base = irq_cnt;
    i_src.hold(1'b1, 30);
    i_src.hold(1'b0, 150);
    `CHK(irq_cnt - base, 0)
    i_src.hold(1'b1, 150);
    i_src.hold(1'b0, 40);
    `CHK(irq_cnt - base, 1)
    set_ctrl(32'h0000_0008, START_FALL);
    base = irq_cnt;
    i_src.hold(1'b1, 30);
    d1 = cyc_n;
    i_src.hold(1'b0, 30);
    i_src.hold(1'b1, 30);
    i_src.hold(1'b0, 30);
    i_src.hold(1'b1, 120);
    `CHK(irq_cnt - base, 1)
    `CHK(last_irq - d1 < 115, 1'b1)
    wr(ADDR_PERIOD, 4'h3, 32'h0000_0003);
    set_ctrl(32'h0000_008c, START_RISE);
    i_src.hold(1'b0, 20);
    base = irq_cnt;
    d1 = irq_hi;
    // Three short glitches would reach a match on their own without the filter
    i_src.pulses(3, 3);
    i_src.hold(1'b0, 20);
    i_src.pulses(6, 20);
    `CHK(irq_cnt - base, 2)
    `CHK(irq_hi - d1, 0)
    bus(1'b0, ADDR_CAPTURE, 4'hf, 32'h0000_0000, q);
    `CHK(q <= 32'h0000_0003, 1'b1)
    wr(ADDR_PERIOD, 4'h3, 32'h0000_0004);
    for (int s = 2; s < 4; s++) begin
      set_ctrl(32'h0000_0009, 2'(s));
      i_src.hold(s == 3, 20);
      base = irq_cnt;
      i_src.hold(s == 3, 150);
      `CHK(irq_cnt - base, 0)
      i_src.hold(s == 2, 150);
      `CHK(irq_cnt - base > 0, 1'b1)
    end
    set_ctrl(32'h0000_0000, START_STOP);
    print_verdict;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    print_verdict;
  end
endmodule
`default_nettype wire
